// File: psp_pkg.sv
// Constants, register map and types of the power stage PWM input unit.
package psp_pkg;
  // ********************************************************************
  // Register bus and map
  // ********************************************************************
  localparam int          DATA_W      = 16;
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  ADR_CTRL    = 8'h00;
  localparam logic [7:0]  ADR_ON_A    = 8'h04;
  localparam logic [7:0]  ADR_ON_B    = 8'h08;
  localparam logic [7:0]  ADR_DEAD_A  = 8'h0c;
  localparam logic [7:0]  ADR_DEAD_B  = 8'h10;
  localparam logic [7:0]  ADR_CYC_B   = 8'h14;
  localparam logic [7:0]  ADR_INP_A   = 8'h18;
  localparam logic [7:0]  ADR_INP_B   = 8'h1c;
  localparam logic [7:0]  ADR_STATUS  = 8'h20;
  // Control register fields.
  localparam int          CTRL_RUN    = 0;
  localparam int          CTRL_ENH    = 1;
  localparam int          CTRL_RAMP_L = 2;
  localparam int          CTRL_RAMP_H = 3;
  // Input control register fields.
  localparam int          IN_MODE_L   = 0;
  localparam int          IN_MODE_H   = 3;
  localparam int          IN_POL      = 4;
  localparam int          IN_FILT     = 5;
  localparam int          IN_SRC      = 6;
  localparam int          IN_AKILL    = 7;
  localparam int          IN_FAULT    = 8;
  localparam int          IN_EDGE     = 9;
  localparam int          IN_W        = 10;
  // Status field and cycle B divider fields; writing one to STS_HALT releases a halt.
  localparam int          STS_HALT    = 0;
  localparam int          FRAC_L      = 12;
  localparam int          FRAC_H      = 15;
  // ********************************************************************
  // Timing and encodings
  // ********************************************************************
  localparam int          CNT_W       = 12;
  localparam int          FRAME_LEN   = 16;
  localparam int          FRAME_W     = 4;
  localparam int          FILTER_LEN  = 4;
  localparam logic [1:0]  RAMP_ONE    = 2'h0;
  localparam logic [1:0]  RAMP_TWO    = 2'h1;
  localparam logic [1:0]  RAMP_FOUR   = 2'h2;
  localparam logic [1:0]  RAMP_CENTER = 2'h3;
  localparam logic [3:0]  MODE_NONE   = 4'h0;
  localparam logic [3:0]  MODE_LAST   = 4'h9;
  localparam logic [3:0]  MODE_BURST  = 4'h3;
  localparam logic [3:0]  MODE_BLANK  = 4'h4;
  localparam logic [3:0]  MODE_HALT   = 4'h7;
  localparam logic [3:0]  MODE_14     = 4'he;
  typedef enum logic [4:0] {
    PH_IDLE   = 5'h01,
    PH_DEAD_A = 5'h02,
    PH_ON_A   = 5'h04,
    PH_DEAD_B = 5'h08,
    PH_ON_B   = 5'h10
  } psp_phase_type;
endpackage

// File: psp_pwm_unit.sv
// Two-output complementary PWM generator with enhanced resolution and input units.
`timescale 1ns/1ns
// ********************************************************************
// Overview of operation
// - Outputs active for twelve-bit on-time counts.
// - Dead-times separate phases; cycle sums four counts.
// - Enhanced mode adds one count in A phase.
// - Frames of sixteen; divider sets lengthened count.
// - Divider factor is top four bits, cycle B.
// - Lengthened cycles spread evenly over the frame.
// - Each half has retrigger-or-fault input unit.
// - Center-aligned mode ignores retrigger inputs.
// - Two/four ramp retrigger jumps to opposite half.
// - One ramp retrigger resets counter to zero.
// - Input A ends output A; off/level/edge.
// - Input B ends output B; same options.
// - Source is comparator or external pin.
// - Optional four-cycle digital input filter.
// - Async kill drops outputs without clock.
// - Polarity bit selects rising/high or falling/low.
// - Two/four ramp: input only in own half, except mode 4 blanking.
// - One ramp: inputs act over whole ramp.
// - Four-bit mode field; reserved codes defined.
// - Mode 4 blanks outputs, timing unchanged.
// - Mode 7 halts until software releases.
// - Level modes 3 and 4 allow bursts.
// ********************************************************************
module psp_pwm_unit (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  // Register port
  input  wire logic [psp_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [psp_pkg::DATA_W-1:0] regWdata,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  output logic      [psp_pkg::DATA_W-1:0] regRdata,
  // Trip sources, index 0 is half A
  input  wire logic [1:0]                 external_trip_pin,
  input  wire logic [1:0]                 comparatorOut,
  // Power stage outputs
  output logic                            pwm_out_a,
  output logic                            pwm_out_b
);
  // ********************************************************************
  // Registers
  // ********************************************************************
  logic [psp_pkg::DATA_W-1:0]  ctrl;
  logic [psp_pkg::CNT_W-1:0]   on_time_a;
  logic [psp_pkg::CNT_W-1:0]   on_time_b;
  logic [psp_pkg::CNT_W-1:0]   dead_time_a;
  logic [psp_pkg::CNT_W-1:0]   dead_time_b;
  logic [psp_pkg::DATA_W-1:0]  cycEndB;
  logic [psp_pkg::IN_W-1:0]    input_ctrl [2];
  logic                        halted;
  logic                        clearHalt;
  logic                        haltReq;
  logic                        runOn;
  logic                        enhanced;
  logic [1:0]                  rampMode;
  logic [psp_pkg::FRAME_W-1:0] fracDiv;

  assign runOn     = ctrl[psp_pkg::CTRL_RUN];
  assign enhanced  = ctrl[psp_pkg::CTRL_ENH];
  assign rampMode  = ctrl[psp_pkg::CTRL_RAMP_H:psp_pkg::CTRL_RAMP_L];
  assign fracDiv   = cycEndB[psp_pkg::FRAC_H:psp_pkg::FRAC_L];
  assign clearHalt = regWr && regAddr == psp_pkg::ADR_STATUS
                     && regWdata[psp_pkg::STS_HALT];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl        <= '0;
      on_time_a   <= '0;
      on_time_b   <= '0;
      dead_time_a <= '0;
      dead_time_b <= '0;
      cycEndB     <= '0;
      input_ctrl  <= '{default: '0};
    end else if (regWr) begin
      case (regAddr)
        psp_pkg::ADR_CTRL:   ctrl        <= regWdata;
        psp_pkg::ADR_ON_A:   on_time_a   <= regWdata[psp_pkg::CNT_W-1:0];
        psp_pkg::ADR_ON_B:   on_time_b   <= regWdata[psp_pkg::CNT_W-1:0];
        psp_pkg::ADR_DEAD_A: dead_time_a <= regWdata[psp_pkg::CNT_W-1:0];
        psp_pkg::ADR_DEAD_B: dead_time_b <= regWdata[psp_pkg::CNT_W-1:0];
        psp_pkg::ADR_CYC_B:  cycEndB     <= regWdata;
        psp_pkg::ADR_INP_A:  input_ctrl[0] <= regWdata[psp_pkg::IN_W-1:0];
        psp_pkg::ADR_INP_B:  input_ctrl[1] <= regWdata[psp_pkg::IN_W-1:0];
        default: ;
      endcase
    end
  end

  // Halt holds until software writes the release bit; a new halt wins.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      halted <= 1'b0;
    end else if (haltReq) begin
      halted <= 1'b1;
    end else if (clearHalt) begin
      halted <= 1'b0;
    end
  end

  // ********************************************************************
  // Input units, one per half
  // ********************************************************************
  psp_pkg::psp_phase_type phase;
  logic [1:0] rawActive;
  logic [1:0] level;
  logic [1:0] event_;
  logic [1:0] inWindow;
  logic [1:0] modeValid;
  logic [1:0] retrig;
  logic [1:0] faultJump;
  logic [1:0] haltHit;
  logic [1:0] gateOwn;
  logic [1:0] gateAll;

  for (genvar h = 0; h < 2; h++) begin : g_input
    logic [psp_pkg::FILTER_LEN-1:0] shiftIn;
    logic                           filtered;
    logic                           levelPrev;
    logic [3:0]                     mode;
    logic                           src;

    assign mode = input_ctrl[h][psp_pkg::IN_MODE_H:psp_pkg::IN_MODE_L];
    assign src  = input_ctrl[h][psp_pkg::IN_SRC] ? comparatorOut[h]
                                                 : external_trip_pin[h];
    assign rawActive[h] = input_ctrl[h][psp_pkg::IN_POL] ? src : ~src;

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        shiftIn   <= '0;
        filtered  <= 1'b0;
        levelPrev <= 1'b0;
      end else begin
        shiftIn   <= {shiftIn[psp_pkg::FILTER_LEN-2:0], rawActive[h]};
        if (&shiftIn) begin
          filtered <= 1'b1;
        end else if (~|shiftIn) begin
          filtered <= 1'b0;
        end
        levelPrev <= level[h];
      end
    end

    assign level[h]  = input_ctrl[h][psp_pkg::IN_FILT] ? filtered : rawActive[h];
    assign event_[h] = input_ctrl[h][psp_pkg::IN_EDGE] ? (level[h] && !levelPrev)
                                                       : level[h];
    // Reserved codes fall outside both valid ranges and do nothing.
    assign modeValid[h] = (mode != psp_pkg::MODE_NONE && mode <= psp_pkg::MODE_LAST)
                          || mode == psp_pkg::MODE_14;
    assign inWindow[h] = (rampMode == psp_pkg::RAMP_ONE) ? 1'b1
                       : (h == 0) ? (phase == psp_pkg::PH_DEAD_A || phase == psp_pkg::PH_ON_A)
                                  : (phase == psp_pkg::PH_DEAD_B
                                     || phase == psp_pkg::PH_ON_B);
    assign retrig[h] = event_[h] && inWindow[h] && modeValid[h]
                       && !input_ctrl[h][psp_pkg::IN_FAULT]
                       && rampMode != psp_pkg::RAMP_CENTER;
    assign haltHit[h] = event_[h] && inWindow[h] && input_ctrl[h][psp_pkg::IN_FAULT]
                        && mode == psp_pkg::MODE_HALT;
    assign faultJump[h] = event_[h] && inWindow[h] && modeValid[h]
                          && input_ctrl[h][psp_pkg::IN_FAULT]
                          && mode != psp_pkg::MODE_HALT
                          && mode != psp_pkg::MODE_BLANK;
    assign gateAll[h] = level[h] && input_ctrl[h][psp_pkg::IN_FAULT]
                        && mode == psp_pkg::MODE_BLANK;
    assign gateOwn[h] = level[h] && input_ctrl[h][psp_pkg::IN_FAULT]
                        && mode == psp_pkg::MODE_BURST;
  end

  assign haltReq = |haltHit;

  // ********************************************************************
  // Waveform sequencer
  // ********************************************************************
  logic [psp_pkg::CNT_W:0]     cnt;
  logic [psp_pkg::CNT_W:0]     phaseLen;
  logic [psp_pkg::FRAME_W-1:0] frameIdx;
  logic [psp_pkg::FRAME_W-1:0] frameRev;
  logic                        extra;
  logic                        lastCnt;
  logic                        jumpToB;
  logic                        jumpToA;
  logic                        restart;

  // Bit-reversed cycle index below d marks the spread-out long cycles.
  assign frameRev = {frameIdx[0], frameIdx[1], frameIdx[2], frameIdx[3]};
  assign extra    = enhanced && (frameRev < fracDiv);

  always_comb begin
    case (phase)
      psp_pkg::PH_DEAD_A: phaseLen = {1'b0, dead_time_a};
      psp_pkg::PH_ON_A:   phaseLen = {1'b0, on_time_a} + {{psp_pkg::CNT_W{1'b0}}, extra};
      psp_pkg::PH_DEAD_B: phaseLen = {1'b0, dead_time_b};
      psp_pkg::PH_ON_B:   phaseLen = {1'b0, on_time_b};
      default:            phaseLen = '0;
    endcase
  end

  // A zero count still spends one clock in its phase.
  assign lastCnt = (cnt + 1'b1) >= phaseLen;
  assign restart = (rampMode == psp_pkg::RAMP_ONE) && (|retrig || |faultJump);
  assign jumpToB = !restart && (retrig[0] || faultJump[0]);
  assign jumpToA = !restart && (retrig[1] || faultJump[1]);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase    <= psp_pkg::PH_IDLE;
      cnt      <= '0;
      frameIdx <= '0;
    end else if (!runOn || halted || haltReq) begin
      phase    <= psp_pkg::PH_IDLE;
      cnt      <= '0;
      frameIdx <= '0;
    end else if (restart) begin
      phase    <= psp_pkg::PH_DEAD_A;
      cnt      <= '0;
      frameIdx <= frameIdx + 1'b1;
    end else if (jumpToB) begin
      phase <= psp_pkg::PH_DEAD_B;
      cnt   <= '0;
    end else if (jumpToA) begin
      phase    <= psp_pkg::PH_DEAD_A;
      cnt      <= '0;
      frameIdx <= frameIdx + 1'b1;
    end else begin
      case (phase)
        psp_pkg::PH_IDLE: begin
          phase <= psp_pkg::PH_DEAD_A;
          cnt   <= '0;
        end
        psp_pkg::PH_DEAD_A: begin
          cnt   <= lastCnt ? '0 : cnt + 1'b1;
          phase <= lastCnt ? psp_pkg::PH_ON_A : psp_pkg::PH_DEAD_A;
        end
        psp_pkg::PH_ON_A: begin
          cnt   <= lastCnt ? '0 : cnt + 1'b1;
          phase <= lastCnt ? psp_pkg::PH_DEAD_B : psp_pkg::PH_ON_A;
        end
        psp_pkg::PH_DEAD_B: begin
          cnt   <= lastCnt ? '0 : cnt + 1'b1;
          phase <= lastCnt ? psp_pkg::PH_ON_B : psp_pkg::PH_DEAD_B;
        end
        psp_pkg::PH_ON_B: begin
          cnt   <= lastCnt ? '0 : cnt + 1'b1;
          phase <= lastCnt ? psp_pkg::PH_DEAD_A : psp_pkg::PH_ON_B;
          if (lastCnt) begin
            frameIdx <= frameIdx + 1'b1;
          end
        end
        default: begin
          phase <= psp_pkg::PH_IDLE;
          cnt   <= '0;
        end
      endcase
    end
  end

  // ********************************************************************
  // Outputs and read port
  // ********************************************************************
  logic outA;
  logic outB;
  logic killAny;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      outA <= 1'b0;
      outB <= 1'b0;
    end else begin
      outA <= phase == psp_pkg::PH_ON_A && !jumpToB && !restart
              && !(|gateAll) && !gateOwn[0];
      outB <= phase == psp_pkg::PH_ON_B && !jumpToA && !restart
              && !(|gateAll) && !gateOwn[1];
    end
  end

  // The kill path bypasses every flip-flop, so it works with the clock stopped.
  assign killAny = (input_ctrl[0][psp_pkg::IN_AKILL] && rawActive[0])
                   || (input_ctrl[1][psp_pkg::IN_AKILL] && rawActive[1]);
  assign pwm_out_a = outA && !killAny;
  assign pwm_out_b = outB && !killAny;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= '0;
    end else if (regRd) begin
      case (regAddr)
        psp_pkg::ADR_CTRL:   regRdata <= ctrl;
        psp_pkg::ADR_ON_A:   regRdata <= {4'h0, on_time_a};
        psp_pkg::ADR_ON_B:   regRdata <= {4'h0, on_time_b};
        psp_pkg::ADR_DEAD_A: regRdata <= {4'h0, dead_time_a};
        psp_pkg::ADR_DEAD_B: regRdata <= {4'h0, dead_time_b};
        psp_pkg::ADR_CYC_B:  regRdata <= cycEndB;
        psp_pkg::ADR_INP_A:  regRdata <= {6'h00, input_ctrl[0]};
        psp_pkg::ADR_INP_B:  regRdata <= {6'h00, input_ctrl[1]};
        psp_pkg::ADR_STATUS: regRdata <= {frameIdx, level, phase, 4'h0, halted};
        default:             regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  property p_out_a_phase;
    @(posedge clk_sys) disable iff (!rst_n)
    outA |-> $past(phase) == psp_pkg::PH_ON_A;
  endproperty
  a_out_a_phase: assert property (p_out_a_phase) else $error("A active outside on-time A");

  property p_no_overlap;
    @(posedge clk_sys) disable iff (!rst_n)
    !(outA && outB);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("outputs overlap");

  property p_dead_to_on;
    @(posedge clk_sys) disable iff (!rst_n)
    (phase == psp_pkg::PH_DEAD_A && lastCnt && runOn && !halted && !haltReq
     && !restart && !jumpToB && !jumpToA) |=> phase == psp_pkg::PH_ON_A && cnt == 0;
  endproperty
  a_dead_to_on: assert property (p_dead_to_on) else $error("dead-time A end wrong");

  property p_extra_len;
    @(posedge clk_sys) disable iff (!rst_n)
    phase == psp_pkg::PH_ON_A |-> phaseLen == {1'b0, on_time_a} + (enhanced
      && frameRev < fracDiv ? 13'h0001 : 13'h0000);
  endproperty
  a_extra_len: assert property (p_extra_len) else $error("extra count wrong");

  property p_frame_wrap;
    @(posedge clk_sys) disable iff (!rst_n)
    (frameIdx == 4'hf && phase == psp_pkg::PH_ON_B && lastCnt && runOn && !halted
     && !haltReq && !restart && !jumpToB && !jumpToA) |=> frameIdx == 4'h0;
  endproperty
  a_frame_wrap: assert property (p_frame_wrap) else $error("frame did not wrap");

  property p_center_ignore;
    @(posedge clk_sys) disable iff (!rst_n)
    (rampMode == psp_pkg::RAMP_CENTER) |-> !(|retrig);
  endproperty
  a_center_ignore: assert property (p_center_ignore) else $error("retrigger in center");

  property p_retrig_jump;
    @(posedge clk_sys) disable iff (!rst_n)
    (retrig[0] && rampMode != psp_pkg::RAMP_ONE && runOn && !halted && !haltReq)
      |=> phase == psp_pkg::PH_DEAD_B && cnt == 0 ##1 !outA;
  endproperty
  a_retrig_jump: assert property (p_retrig_jump) else $error("retrigger A no jump");

  property p_one_ramp;
    @(posedge clk_sys) disable iff (!rst_n)
    (restart && runOn && !halted && !haltReq) |=> phase == psp_pkg::PH_DEAD_A && cnt == 0;
  endproperty
  a_one_ramp: assert property (p_one_ramp) else $error("one ramp no reset");

  property p_halt;
    @(posedge clk_sys) disable iff (!rst_n)
    haltReq |=> halted ##1 (!outA && !outB && phase == psp_pkg::PH_IDLE);
  endproperty
  a_halt: assert property (p_halt) else $error("halt not taken");

  property p_blank;
    @(posedge clk_sys) disable iff (!rst_n)
    (|gateAll) |=> !outA && !outB;
  endproperty
  a_blank: assert property (p_blank) else $error("mode 4 did not blank");
endmodule

// File: psp_trip_model.sv
// Model of the power stage and its trip sources seen from the unit.
`timescale 1ns/1ns
module psp_trip_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Gate drives from the unit
  input  wire logic       pwm_out_a,
  input  wire logic       pwm_out_b,
  // Trip requests, sense level and source choice per half
  input  wire logic [1:0] trip,
  input  wire logic [1:0] activeHigh,
  input  wire logic [1:0] useComparator,
  // Trip sources towards the unit
  output logic      [1:0] external_trip_pin,
  output logic      [1:0] comparatorOut,
  // Width of the last finished pulse on each output
  output int              widthA,
  output int              widthB
);
  logic [1:0] sense;
  int         cntA;
  int         cntB;

  // The source not in use shows the opposite of the chosen one, so a wrong pick trips early.
  assign sense = trip ~^ activeHigh;
  assign external_trip_pin = (sense & ~useComparator) | (~sense & useComparator);
  assign comparatorOut = (sense & useComparator) | (~sense & ~useComparator);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cntA <= 0;
      cntB <= 0;
      widthA <= 0;
      widthB <= 0;
    end else begin
      cntA <= pwm_out_a ? cntA + 1 : 0;
      cntB <= pwm_out_b ? cntB + 1 : 0;
      if (!pwm_out_a && cntA > 0) begin
        widthA <= cntA;
      end
      if (!pwm_out_b && cntB > 0) begin
        widthB <= cntB;
      end
    end
  end
endmodule

// File: testbench.sv
// Self-checking testbench of the power stage PWM input unit.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module testbench;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [15:0] regWdata = 16'h0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [15:0] regRdata;
  logic [1:0]  trip = 2'h0;
  logic [1:0]  activeHigh = 2'h1;
  logic [1:0]  useComparator = 2'h0;
  logic [1:0]  external_trip_pin;
  logic [1:0]  comparatorOut;
  logic        pwm_out_a;
  logic        pwm_out_b;
  int          widthA;
  int          widthB;
  int          miscompares = 0;
  int          checks = 0;
  int          c;
  int          i;
  logic [15:0] v;
  logic [3:0]  idle [6] = '{4'h0, 4'ha, 4'hb, 4'hc, 4'hd, 4'hf};

  always #2 clk_sys = ~clk_sys;

  psp_pwm_unit dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .external_trip_pin(external_trip_pin), .comparatorOut(comparatorOut),
    .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b));

  psp_trip_model stage_u (.clk_sys(clk_sys), .rst_n(rst_n), .pwm_out_a(pwm_out_a),
    .pwm_out_b(pwm_out_b), .trip(trip), .activeHigh(activeHigh),
    .useComparator(useComparator), .external_trip_pin(external_trip_pin),
    .comparatorOut(comparatorOut), .widthA(widthA), .widthB(widthB));

  // ********************************************************************
  // Bus and waveform tasks
  // ********************************************************************
  task finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  task waitLvl(input bit b, input bit l);
    int n;
    n = 0;
    while ((b ? pwm_out_b : pwm_out_a) !== l) begin
      @(posedge clk_sys);
      #1 n++;
      if (n > 500) begin
        miscompares++;
        $display("[FAIL] output level exp %0h got timeout", l);
        finish_test();
      end
    end
  endtask

  // Waits for a fresh rising edge, never the middle of a pulse that is already running.
  task rise(input bit b);
    waitLvl(b, 1'b0);
    waitLvl(b, 1'b1);
  endtask

  // Waits for the running pulse to end and lets the model store its width.
  task waitPulse(input bit b);
    waitLvl(b, 1'b1);
    waitLvl(b, 1'b0);
    @(posedge clk_sys);
    #1;
  endtask

  // Cycles spanned by n periods of output A, from one rising edge on.
  task period(input int n, output int cy);
    int r;
    int g;
    bit p;
    r = -1;
    g = 0;
    cy = 0;
    p = 1'b1;
    while (r < n && g < 6000) begin
      @(posedge clk_sys);
      #1 g++;
      if (r >= 0) cy++;
      if (pwm_out_a && !p) r++;
      p = pwm_out_a;
    end
    if (r < n) begin
      miscompares++;
      $display("[FAIL] period exp %0d got timeout", n);
      finish_test();
    end
  endtask

  // Counts cycles with output A high, and output B as well when withB is set.
  task quiet(input int n, input bit withB, output int hits);
    hits = 0;
    repeat (n) begin
      @(posedge clk_sys);
      #1 hits += (pwm_out_a | (pwm_out_b & withB));
    end
  endtask

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(psp_pkg::ADR_CTRL, v);
    `CHK("ctrl", 16'h0000, v)
    rd(8'h24, v);
    `CHK("unmapped", 16'h0000, v)
    wr(psp_pkg::ADR_DEAD_A, 16'h0002);
    wr(psp_pkg::ADR_ON_A, 16'hf005);
    wr(psp_pkg::ADR_DEAD_B, 16'h0003);
    wr(psp_pkg::ADR_ON_B, 16'h0004);
    rd(psp_pkg::ADR_ON_A, v);
    `CHK("onA", 16'h0005, v)
    wr(psp_pkg::ADR_CTRL, 16'h0005);
    waitPulse(1'b0);
    `CHK("widthA", 5, widthA)
    waitPulse(1'b1);
    `CHK("widthB", 4, widthB)
    period(4, c);
    `CHK("period", 56, c)
    // Any sixteen periods hold every frame slot once, so d extra counts in all.
    foreach (idle[i]) begin
      if (i < 3) begin
        wr(psp_pkg::ADR_CYC_B, {i == 0 ? 4'h0 : (i == 1 ? 4'h4 : 4'hf), 12'h000});
        wr(psp_pkg::ADR_CTRL, 16'h0007);
        period(16, c);
        period(16, c);
        `CHK("frame", (i == 0 ? 224 : (i == 1 ? 228 : 239)), c)
      end
    end
    wr(psp_pkg::ADR_CTRL, 16'h0005);
    wr(psp_pkg::ADR_ON_A, 16'h0028);
    for (i = 0; i < 8; i++) begin
      activeHigh <= {1'b0, i[0]};
      useComparator <= {1'b0, i[1]};
      wr(psp_pkg::ADR_INP_A, 16'h0201 | {i[1], 1'b0, i[0], 4'h0});
      wr(psp_pkg::ADR_CTRL, i[2] ? 16'h0001 : (i[0] ? 16'h0009 : 16'h0005));
      rise(1'b0);
      repeat (5) @(posedge clk_sys);
      trip <= 2'h1;
      waitPulse(1'b0);
      `CHK("cutA", 1'b1, widthA > 4 && widthA < 12)
      trip <= 2'h0;
    end
    activeHigh <= 2'h1;
    useComparator <= 2'h0;
    wr(psp_pkg::ADR_CTRL, 16'h0005);
    wr(psp_pkg::ADR_INP_A, 16'h0031);
    rise(1'b0);
    repeat (5) @(posedge clk_sys);
    trip <= 2'h1;
    repeat (2) @(posedge clk_sys);
    trip <= 2'h0;
    waitPulse(1'b0);
    `CHK("glitch", 40, widthA)
    wr(psp_pkg::ADR_CTRL, 16'h000d);
    wr(psp_pkg::ADR_INP_A, 16'h0211);
    rise(1'b0);
    trip <= 2'h1;
    waitPulse(1'b0);
    `CHK("center", 40, widthA)
    trip <= 2'h0;
    wr(psp_pkg::ADR_CTRL, 16'h0005);
    foreach (idle[i]) begin
      wr(psp_pkg::ADR_INP_A, {12'h001, idle[i]});
      trip <= 2'h1;
      waitPulse(1'b0);
      `CHK("noAction", 40, widthA)
      trip <= 2'h0;
    end
    wr(psp_pkg::ADR_INP_A, 16'h0114);
    trip <= 2'h1;
    repeat (4) @(posedge clk_sys);
    quiet(60, 1'b1, c);
    `CHK("blank", 0, c)
    trip <= 2'h0;
    waitPulse(1'b0);
    period(1, c);
    `CHK("blankPeriod", 49, c)
    wr(psp_pkg::ADR_INP_A, 16'h0113);
    trip <= 2'h1;
    repeat (4) @(posedge clk_sys);
    quiet(60, 1'b0, c);
    `CHK("burstA", 0, c)
    waitPulse(1'b1);
    `CHK("burstB", 4, widthB)
    trip <= 2'h0;
    // The kill lands on an edge whose flops saw the trip idle, so only the direct path acts.
    wr(psp_pkg::ADR_INP_A, 16'h0094);
    rise(1'b0);
    repeat (2) @(posedge clk_sys);
    trip <= 2'h1;
    #1 `CHK("kill", 1'b0, pwm_out_a)
    @(posedge clk_sys);
    trip <= 2'h0;
    wr(psp_pkg::ADR_INP_A, 16'h0117);
    rise(1'b0);
    trip <= 2'h1;
    repeat (5) @(posedge clk_sys);
    trip <= 2'h0;
    quiet(40, 1'b1, c);
    `CHK("halted", 0, c)
    rd(psp_pkg::ADR_STATUS, v);
    `CHK("status", 16'h0021, v)
    wr(psp_pkg::ADR_INP_A, 16'h0000);
    wr(psp_pkg::ADR_STATUS, 16'h0001);
    rd(psp_pkg::ADR_STATUS, v);
    `CHK("release", 1'b0, v[0])
    finish_test();
  end
endmodule
